// *** lspfm_pkg.sv ***
package lspfm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_SYS_IO_CFG  = 8'h5C;
	localparam logic [7:0] REG_KBC_BASE_LO = 8'h60;
	localparam logic [7:0] REG_KBC_BASE_HI = 8'h61;
	localparam logic [7:0] REG_ROM_LO      = 8'h62;
	localparam logic [7:0] REG_ROM_HI      = 8'h63;
	localparam logic [7:0] REG_USB_CTL     = 8'h64;
	localparam logic [7:0] REG_IRQ_STAT    = 8'h65;
	localparam logic [7:0] REG_IRQ_MASK    = 8'h66;
	localparam logic [7:0] REG_PIN_STAT    = 8'h67;

	// ----------------------------------------
	// Configuration fields and reset values
	// ----------------------------------------
	localparam int CFG_PNF_SEL = 0;
	localparam int CFG_PWR_SEL = 1;
	localparam int CFG_ECP     = 2;
	localparam int CFG_VKBD    = 4;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [15:0] KBC_BASE_RESET = 16'h0060;
	localparam logic [7:0]  ROM_LO_RESET   = 8'h0E;
	localparam logic [7:0]  ROM_HI_RESET   = 8'h0F;
	localparam logic [1:0]  USB_CTL_RESET  = 2'h0;

	// ----------------------------------------
	// Host I/O locations
	// ----------------------------------------
	localparam logic [15:0] KBC_DATA_OFS  = 16'h0000;
	localparam logic [15:0] KBC_CMD_OFS   = 16'h0004;
	localparam logic [15:0] PM_OFS_A      = 16'h0002;
	localparam logic [15:0] PM_OFS_B      = 16'h0006;
	localparam logic [15:0] CLK_ADDR_PORT = 16'h0070;
	localparam logic [15:0] CLK_DATA_PORT = 16'h0071;

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	localparam int NUM_EV     = 4;
	localparam int EV_CLK_IRQ = 0;
	localparam int EV_OC1     = 1;
	localparam int EV_OC2     = 2;
	localparam int EV_USB_ACT = 3;

	// ----------------------------------------
	// Synchroniser bit positions
	// ----------------------------------------
	localparam int SYNC_W    = 17;
	localparam int SY_PD     = 0;
	localparam int SY_CTL    = 8;
	localparam int SY_STRAP  = 13;
	localparam int SY_CLKIRQ = 14;
	localparam int SY_OC     = 15;
	// Over-current bits reset to their idle low level so no false event follows reset
	localparam logic [16:0] SYNC_RESET = 17'h07FFF;

	// ----------------------------------------
	// Shared pin groups
	// ----------------------------------------
	localparam int CTL_ACK  = 0;
	localparam int CTL_BUSY = 1;
	localparam int CTL_PE   = 2;
	localparam int CTL_SLCT = 3;
	localparam int CTL_ERR  = 4;
	localparam int OUT_STB  = 0;
	localparam int OUT_PRINTER_SELECT_IN_N = 1;
	localparam int OUT_INIT = 2;
	localparam int OUT_AFD  = 3;
	localparam int FO_DENS1 = 0;
	localparam int FO_DS1   = 1;
	localparam int FO_MOTOR_ON_1_N  = 2;
	localparam int FO_WDATA = 3;
	localparam int FO_WRITE_GATE_N = 4;
	localparam int FO_HEAD_SEL_N = 5;
	localparam int FO_STEP  = 6;
	localparam int FO_DIR   = 7;
	localparam int FO_DENS0 = 8;
	localparam int PD_DENS1 = 6;
	localparam logic [7:0] PD_FLOPPY_OE_N = 8'hBF;

	typedef enum logic {ROUTE_PRINTER, ROUTE_FLOPPY} lspfm_route_type;

endpackage

// *** lspfm_sync.sv ***
`timescale 1ns/10ps
module lspfm_sync
	import lspfm_pkg::*;
#(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;

	// ----------------------------------------
	// Three stages, change taken when two agree
	// ----------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				ff1_q[i]    <= RST_VAL[i];
				ff2_q[i]    <= RST_VAL[i];
				ff3_q[i]    <= RST_VAL[i];
				sync_out[i] <= RST_VAL[i];
			end else begin
				ff1_q[i] <= async_in[i];
				ff2_q[i] <= ff1_q[i];
				ff3_q[i] <= ff2_q[i];
				if (ff2_q[i] == ff3_q[i]) begin
					sync_out[i] <= ff3_q[i];
				end
			end
		end
	end

endmodule // lspfm_sync

// *** lspfm_pin_mux.sv ***
`timescale 1ns/10ps
module lspfm_pin_mux
	import lspfm_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Routing choice
	input  wire logic       floppy,
	input  wire logic       ecp,
	// Parallel and floppy cores
	input  wire logic [7:0] pp_data_out,
	input  wire logic       pp_data_drive,
	input  wire logic [3:0] pp_ctl_out,
	input  wire logic [2:0] ecp_out,
	input  wire logic [8:0] fdc_out,
	output logic      [7:0] pp_data_in,
	output logic      [4:0] pp_status,
	output logic      [7:0] fdc_in,
	// Shared pins
	input  wire logic [7:0] pd_in,
	input  wire logic [4:0] ctl_in,
	output logic      [7:0] pd_out,
	output logic      [7:0] pd_oe_n,
	output logic      [4:0] ctl_out,
	output logic      [4:0] ctl_oe_n,
	output logic      [3:0] out_pins
);

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Data and status pins start undriven and the four output pins start high, so neither a printer nor a drive sees a glitch at reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pd_out   <= 8'h00;
			pd_oe_n  <= 8'hFF;
			ctl_out  <= 5'h1F;
			ctl_oe_n <= 5'h1F;
			out_pins <= 4'hF;
		end else if (floppy) begin
			pd_out             <= 8'h00;
			pd_out[PD_DENS1]   <= fdc_out[FO_DENS1];
			pd_oe_n            <= PD_FLOPPY_OE_N;
			ctl_out[CTL_ACK]   <= fdc_out[FO_DS1];
			ctl_out[CTL_BUSY]  <= fdc_out[FO_MOTOR_ON_1_N];
			ctl_out[CTL_PE]    <= fdc_out[FO_WDATA];
			ctl_out[CTL_SLCT]  <= fdc_out[FO_WRITE_GATE_N];
			ctl_out[CTL_ERR]   <= fdc_out[FO_HEAD_SEL_N];
			ctl_oe_n           <= 5'h00;
			out_pins[OUT_STB]  <= 1'b1;
			out_pins[OUT_PRINTER_SELECT_IN_N] <= fdc_out[FO_STEP];
			out_pins[OUT_INIT] <= fdc_out[FO_DIR];
			out_pins[OUT_AFD]  <= fdc_out[FO_DENS0];
		end else begin
			pd_out             <= pp_data_out;
			pd_oe_n            <= {8{!pp_data_drive}};
			ctl_out            <= 5'h1F;
			ctl_oe_n           <= 5'h1F;
			out_pins[OUT_STB]  <= ecp ? ecp_out[0] : pp_ctl_out[OUT_STB];
			out_pins[OUT_PRINTER_SELECT_IN_N] <= ecp ? ecp_out[1] : pp_ctl_out[OUT_PRINTER_SELECT_IN_N];
			out_pins[OUT_INIT] <= pp_ctl_out[OUT_INIT];
			out_pins[OUT_AFD]  <= ecp ? ecp_out[2] : pp_ctl_out[OUT_AFD];
		end
	end

	// ----------------------------------------
	// Inputs back to the cores
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pp_data_in <= 8'h00;
			pp_status  <= 5'h00;
			fdc_in     <= 8'hFF;
		end else begin
			pp_data_in <= floppy ? 8'h00 : pd_in;
			pp_status  <= floppy ? 5'h00 : ctl_in;
			fdc_in     <= floppy ? (pd_in & PD_FLOPPY_OE_N) : 8'hBF;
		end
	end

endmodule // lspfm_pin_mux

// *** lspfm_top.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module lspfm_top
	import lspfm_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             irq,
	// Host cycles
	input  wire logic [23:0] host_addr,
	input  wire logic        host_io_cyc,
	input  wire logic        host_mem_cyc,
	input  wire logic        host_write,
	// Selects and strobes
	output logic             kbd_ctrl_select_n,
	output logic             clock_addr_latch,
	output logic             clock_chip_select_n,
	output logic             boot_rom_select_n,
	input  wire logic        clock_irq_n,
	// USB root hub
	input  wire logic [1:0]  hc_port_power,
	input  wire logic        hc_activity,
	input  wire logic [1:0]  port_overcurrent_in,
	output logic      [1:0]  port_power_ctl_n,
	output logic      [1:0]  hc_overcurrent,
	output logic             usb_activity,
	// Strap
	input  wire logic        printer_not_floppy_strap,
	// Shared printer and floppy pins
	input  wire logic [7:0]  pd_in,
	output logic      [7:0]  pd_out,
	output logic      [7:0]  pd_oe_n,
	input  wire logic [4:0]  ctl_in,
	output logic      [4:0]  ctl_out,
	output logic      [4:0]  ctl_oe_n,
	output logic      [3:0]  out_pins,
	// Parallel and floppy cores
	input  wire logic [7:0]  pp_data_out,
	input  wire logic        pp_data_drive,
	input  wire logic [3:0]  pp_ctl_out,
	input  wire logic [2:0]  ecp_out,
	input  wire logic [8:0]  fdc_out,
	output logic      [7:0]  pp_data_in,
	output logic      [4:0]  pp_status,
	output logic      [7:0]  fdc_in
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]        cfg_q;
	logic [15:0]       kbd_ctrl_base_q;
	logic [7:0]        rom_lo_q;
	logic [7:0]        rom_hi_q;
	logic [1:0]        usb_ctl_q;
	logic [NUM_EV-1:0] stat_q;
	logic [NUM_EV-1:0] stat_d;
	logic [NUM_EV-1:0] mask_q;
	logic [NUM_EV-1:0] ev;
	logic [SYNC_W-1:0] sync_out;
	logic              clk_irq_prev_q;
	logic [1:0]        oc_prev_q;
	logic              act_prev_q;
	lspfm_route_type   route_q;
	logic              kbd_hit;
	logic              pm_hit;
	logic              clk_hit;
	logic              rom_hit;
	logic              latch_hit;

	// Exact 16-bit I/O port compare, shared by every select except the boot ROM range
	function automatic logic io_hit(input logic [23:0] a, input logic [15:0] port);
		return a[15:0] == port;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	lspfm_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RESET)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({port_overcurrent_in, clock_irq_n, printer_not_floppy_strap, ctl_in, pd_in}),
		.sync_out (sync_out)
	);

	// ----------------------------------------
	// Host address decode
	// ----------------------------------------
	always_comb begin
		kbd_hit = io_hit(host_addr, 16'(kbd_ctrl_base_q + KBC_DATA_OFS))
			|| io_hit(host_addr, 16'(kbd_ctrl_base_q + KBC_CMD_OFS));
		pm_hit = io_hit(host_addr, 16'(kbd_ctrl_base_q + PM_OFS_A))
			|| io_hit(host_addr, 16'(kbd_ctrl_base_q + PM_OFS_B));
		clk_hit = io_hit(host_addr, CLK_DATA_PORT)
			|| (cfg_q[CFG_VKBD] && io_hit(host_addr, CLK_ADDR_PORT));
		latch_hit = host_write && io_hit(host_addr, CLK_ADDR_PORT);
		rom_hit = (host_addr[23:16] >= rom_lo_q) && (host_addr[23:16] <= rom_hi_q);
	end

	// ----------------------------------------
	// Chip selects and strobes
	// ----------------------------------------
	// Registered one cycle behind the host cycle so the pins never glitch on decode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			kbd_ctrl_select_n   <= 1'b1;
			clock_addr_latch    <= 1'b0;
			clock_chip_select_n <= 1'b1;
			boot_rom_select_n   <= 1'b1;
		end else begin
			kbd_ctrl_select_n   <= !(host_io_cyc && kbd_hit);
			clock_chip_select_n <= !(host_io_cyc && clk_hit);
			boot_rom_select_n   <= !(host_mem_cyc && rom_hit);
			if (cfg_q[CFG_PWR_SEL]) begin
				clock_addr_latch <= !(host_io_cyc && pm_hit);
			end else begin
				clock_addr_latch <= host_io_cyc && latch_hit;
			end
		end
	end

	// ----------------------------------------
	// USB root hub pins
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_power_ctl_n <= 2'h3;
			hc_overcurrent   <= 2'h0;
			usb_activity     <= 1'b0;
		end else begin
			port_power_ctl_n <= ~(hc_port_power & usb_ctl_q);
			hc_overcurrent   <= sync_out[SY_OC +: 2];
			usb_activity     <= hc_activity;
		end
	end

	// ----------------------------------------
	// Routing choice
	// ----------------------------------------
	// Strap is looked at only through the select bit, so a floating strap is harmless
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			route_q <= ROUTE_PRINTER;
		end else if (cfg_q[CFG_PNF_SEL] && !sync_out[SY_STRAP]) begin
			route_q <= ROUTE_FLOPPY;
		end else begin
			route_q <= ROUTE_PRINTER;
		end
	end

	lspfm_pin_mux u_pin_mux (
		.clock         (clock),
		.rst_n         (rst_n),
		.floppy        (route_q == ROUTE_FLOPPY),
		.ecp           (cfg_q[CFG_ECP]),
		.pp_data_out   (pp_data_out),
		.pp_data_drive (pp_data_drive),
		.pp_ctl_out    (pp_ctl_out),
		.ecp_out       (ecp_out),
		.fdc_out       (fdc_out),
		.pp_data_in    (pp_data_in),
		.pp_status     (pp_status),
		.fdc_in        (fdc_in),
		.pd_in         (sync_out[SY_PD +: 8]),
		.ctl_in        (sync_out[SY_CTL +: 5]),
		.pd_out        (pd_out),
		.pd_oe_n       (pd_oe_n),
		.ctl_out       (ctl_out),
		.ctl_oe_n      (ctl_oe_n),
		.out_pins      (out_pins)
	);

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clk_irq_prev_q <= 1'b1;
			oc_prev_q      <= 2'h0;
			act_prev_q     <= 1'b0;
		end else begin
			clk_irq_prev_q <= sync_out[SY_CLKIRQ];
			oc_prev_q      <= sync_out[SY_OC +: 2];
			act_prev_q     <= hc_activity;
		end
	end

	always_comb begin
		ev             = '0;
		ev[EV_CLK_IRQ] = clk_irq_prev_q && !sync_out[SY_CLKIRQ];
		ev[EV_OC1]     = !oc_prev_q[0] && sync_out[SY_OC];
		ev[EV_OC2]     = !oc_prev_q[1] && sync_out[SY_OC + 1];
		ev[EV_USB_ACT] = !act_prev_q && hc_activity;
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	// Set wins over a write-one-to-clear in the same cycle
	always_comb begin
		stat_d = stat_q;
		if (reg_wr && reg_addr == REG_IRQ_STAT) begin
			stat_d = stat_d & ~reg_wdata[NUM_EV-1:0];
		end
		stat_d = stat_d | ev;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stat_q <= '0;
			irq    <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq    <= |(stat_d & mask_q);
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_q           <= CFG_RESET;
			kbd_ctrl_base_q <= KBC_BASE_RESET;
			rom_lo_q        <= ROM_LO_RESET;
			rom_hi_q        <= ROM_HI_RESET;
			usb_ctl_q       <= USB_CTL_RESET;
			mask_q          <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_SYS_IO_CFG:  cfg_q                 <= reg_wdata;
				REG_KBC_BASE_LO: kbd_ctrl_base_q[7:0]  <= reg_wdata;
				REG_KBC_BASE_HI: kbd_ctrl_base_q[15:8] <= reg_wdata;
				REG_ROM_LO:      rom_lo_q              <= reg_wdata;
				REG_ROM_HI:      rom_hi_q              <= reg_wdata;
				REG_USB_CTL:     usb_ctl_q             <= reg_wdata[1:0];
				REG_IRQ_MASK:    mask_q                <= reg_wdata[NUM_EV-1:0];
				default:         cfg_q                 <= cfg_q;
			endcase
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Data stands only in the cycle after each reg_rd cycle; unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (!rst_n || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				REG_SYS_IO_CFG:  reg_rdata <= cfg_q;
				REG_KBC_BASE_LO: reg_rdata <= kbd_ctrl_base_q[7:0];
				REG_KBC_BASE_HI: reg_rdata <= kbd_ctrl_base_q[15:8];
				REG_ROM_LO:      reg_rdata <= rom_lo_q;
				REG_ROM_HI:      reg_rdata <= rom_hi_q;
				REG_USB_CTL:     reg_rdata <= {6'h00, usb_ctl_q};
				REG_IRQ_STAT:    reg_rdata <= {4'h0, stat_q};
				REG_IRQ_MASK:    reg_rdata <= {4'h0, mask_q};
				REG_PIN_STAT:    reg_rdata <= {3'h0, route_q == ROUTE_FLOPPY,
					sync_out[SY_STRAP], sync_out[SY_OC +: 2], sync_out[SY_CLKIRQ]};
				default:         reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_kbd_select_hit: assert property (
		host_io_cyc && kbd_hit |=> !kbd_ctrl_select_n
	) else $error("keyboard select missed on its port");

	a_latch_write_only: assert property (
		!cfg_q[CFG_PWR_SEL] && !(host_io_cyc && latch_hit) |=> !clock_addr_latch
	) else $error("latch strobe without a write to its port");

	a_pm_select_hit: assert property (
		cfg_q[CFG_PWR_SEL] && host_io_cyc && pm_hit |=> !clock_addr_latch
	) else $error("power select missed on its port");

	a_clk_select_vkbd: assert property (
		host_io_cyc && cfg_q[CFG_VKBD] && host_addr[15:0] == CLK_ADDR_PORT
		|=> !clock_chip_select_n
	) else $error("clock select missed in virtual keyboard option");

	a_clk_select_plain: assert property (
		host_io_cyc && !cfg_q[CFG_VKBD] && host_addr[15:0] == CLK_ADDR_PORT
		|=> clock_chip_select_n
	) else $error("clock select on address port without option");

	a_rom_select_range: assert property (
		boot_rom_select_n == !($past(host_mem_cyc) && $past(rom_hit))
	) else $error("boot ROM select disagrees with range");

	a_strap_ignored: assert property (
		!cfg_q[CFG_PNF_SEL] |=> route_q == ROUTE_PRINTER ##1 pd_oe_n != PD_FLOPPY_OE_N
			|| pp_data_drive
	) else $error("strap acted while select bit clear");

	a_floppy_enables: assert property (
		route_q == ROUTE_FLOPPY |=> pd_oe_n == PD_FLOPPY_OE_N && ctl_oe_n == 5'h00
	) else $error("floppy pin enables wrong");

	a_printer_ctl_in: assert property (
		route_q == ROUTE_PRINTER |=> ctl_oe_n == 5'h1F
	) else $error("printer status pins driven");

	a_power_follows: assert property (
		##1 port_power_ctl_n == ~($past(hc_port_power) & $past(usb_ctl_q))
	) else $error("port power control wrong");

	a_clk_irq_sets: assert property (
		ev[EV_CLK_IRQ] |=> stat_q[EV_CLK_IRQ]
	) else $error("clock interrupt event lost");

	c_floppy_route:  cover property (route_q == ROUTE_PRINTER ##1 route_q == ROUTE_FLOPPY);
	c_latch_strobe:  cover property (!clock_addr_latch ##1 clock_addr_latch);
	c_irq_raised:    cover property (!irq ##1 irq);
	c_set_and_clear: cover property (ev != '0 && reg_wr && reg_addr == REG_IRQ_STAT);

endmodule // lspfm_top

// *** lspfm_far_end.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Far side: clock chip, power switch, drive or printer
// ----------------------------------------
module lspfm_far_end
	import lspfm_pkg::*;
(
	// Bench control
	input  wire logic       irq_req,
	input  wire logic [1:0] oc_req,
	input  wire logic [7:0] pd_drv,
	input  wire logic [4:0] ctl_drv,
	// Device pins
	input  wire logic [7:0] pd_out,
	input  wire logic [7:0] pd_oe_n,
	input  wire logic [4:0] ctl_out,
	input  wire logic [4:0] ctl_oe_n,
	output logic      [7:0] pd_in,
	output logic      [4:0] ctl_in,
	output logic            clock_irq_n,
	output logic      [1:0] port_overcurrent_in
);
	// Clock chip requests by pulling its line low
	assign clock_irq_n = ~irq_req;
	// Regulator reports a shutdown on the sense line of that port
	assign port_overcurrent_in = oc_req;
	// Wire level: device wins where it drives, so a bad enable shows as wrong data
	assign pd_in = (pd_out & ~pd_oe_n) | (pd_drv & pd_oe_n);
	assign ctl_in = (ctl_out & ~ctl_oe_n) | (ctl_drv & ctl_oe_n);
endmodule // lspfm_far_end

// *** lspfm_top_tb_top.sv ***
`timescale 1ns/10ps
module lspfm_top_tb_top
	import lspfm_pkg::*;
;
	typedef struct packed {
		logic [7:0]  cfg;
		logic        mem;
		logic        wr;
		logic [23:0] a;
		logic [3:0]  e;
	} lspfm_row_type;
	logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, host_io_cyc = 0, host_mem_cyc = 0;
	logic host_write = 0, hc_activity = 0, strap = 0, pp_data_drive = 0, irq_req = 0, irq;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, pp_data_out = 8'hA5, pd_drv = 8'hFC;
	logic [7:0] pd_in, pd_out, pd_oe_n, pp_data_in, fdc_in, d;
	logic [23:0] host_addr = 0;
	logic [1:0] hc_port_power = 0, oc_req = 0, port_overcurrent_in, port_power_ctl_n, hc_oc;
	logic [4:0] ctl_in, ctl_out, ctl_oe_n, pp_status, ctl_drv = 5'h16;
	logic [3:0] out_pins, pp_ctl_out = 4'hA;
	logic [2:0] ecp_out = 3'h5;
	logic [8:0] fdc_out = 9'h15A;
	logic kbd_n, latch, rtc_n, rom_n, clock_irq_n, usb_activity;
	int failures = 0, n_tests = 0;
	wire [7:0] sel = {4'h0, kbd_n, latch, rtc_n, rom_n};
	lspfm_row_type rows[15] = '{
		'{8'h00, 0, 0, 24'h000060, 4'h3}, '{8'h00, 0, 1, 24'h000064, 4'h3},
		'{8'h00, 0, 1, 24'h000070, 4'hF}, '{8'h00, 0, 0, 24'h000070, 4'hB},
		'{8'h00, 0, 0, 24'h000071, 4'h9}, '{8'h00, 0, 1, 24'h000072, 4'hB},
		'{8'h10, 0, 0, 24'h000070, 4'h9}, '{8'h10, 0, 1, 24'h000071, 4'h9},
		'{8'h02, 0, 0, 24'h000062, 4'hB}, '{8'h02, 0, 1, 24'h000066, 4'hB},
		'{8'h02, 0, 1, 24'h000070, 4'hF}, '{8'h00, 1, 0, 24'h0E1234, 4'hA},
		'{8'h00, 1, 0, 24'h0F0000, 4'hA}, '{8'h00, 1, 0, 24'h100000, 4'hB},
		'{8'h00, 1, 0, 24'h0D0000, 4'hB}};

	always #25 clock = ~clock;

	lspfm_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.host_addr(host_addr), .host_io_cyc(host_io_cyc), .host_mem_cyc(host_mem_cyc),
		.host_write(host_write), .kbd_ctrl_select_n(kbd_n), .clock_addr_latch(latch),
		.clock_chip_select_n(rtc_n), .boot_rom_select_n(rom_n), .clock_irq_n(clock_irq_n),
		.hc_port_power(hc_port_power), .hc_activity(hc_activity),
		.port_overcurrent_in(port_overcurrent_in), .port_power_ctl_n(port_power_ctl_n),
		.hc_overcurrent(hc_oc), .usb_activity(usb_activity),
		.printer_not_floppy_strap(strap), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
		.ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n), .out_pins(out_pins),
		.pp_data_out(pp_data_out), .pp_data_drive(pp_data_drive), .pp_ctl_out(pp_ctl_out),
		.ecp_out(ecp_out), .fdc_out(fdc_out), .pp_data_in(pp_data_in),
		.pp_status(pp_status), .fdc_in(fdc_in));

	lspfm_far_end far (.irq_req(irq_req), .oc_req(oc_req), .pd_drv(pd_drv),
		.ctl_drv(ctl_drv), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .ctl_out(ctl_out),
		.ctl_oe_n(ctl_oe_n), .pd_in(pd_in), .ctl_in(ctl_in), .clock_irq_n(clock_irq_n),
		.port_overcurrent_in(port_overcurrent_in));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
	endtask

	task rreg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clock);
		reg_rd <= 0;
		@(negedge clock);
		v = reg_rdata;
	endtask

	// Selects lag one cycle, so look just after the sampling edge
	task host(input lspfm_row_type r);
		@(posedge clock);
		host_io_cyc <= ~r.mem;
		host_mem_cyc <= r.mem;
		host_write <= r.wr;
		host_addr <= r.a;
		@(posedge clock);
		host_io_cyc <= 0;
		host_mem_cyc <= 0;
		@(negedge clock);
		chk("select", {4'h0, r.e}, sel);
		@(negedge clock);
		chk("idle", {5'h1, r.cfg[CFG_PWR_SEL], 2'h3}, sel);
	endtask

	// Strap passes synchronisers, then strap and config pass the route and mux registers
	task mux(input logic [7:0] c, input logic s);
		@(posedge clock);
		strap <= s;
		wreg(REG_SYS_IO_CFG, c);
		repeat (12) @(posedge clock);
		@(negedge clock);
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		stop_test;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1;
		@(negedge clock);
		chk("rst sel", 8'h0B, sel);
		chk("rst usb", 8'h30, {2'h0, port_power_ctl_n, hc_oc, irq, usb_activity});
		rreg(REG_SYS_IO_CFG, d);
		chk("cfg", CFG_RESET, d);
		rreg(REG_KBC_BASE_LO, d);
		chk("kbc base", KBC_BASE_RESET[7:0], d);
		rreg(8'h80, d);
		chk("unmapped", 8'h00, d);
		wreg(REG_SYS_IO_CFG, 8'h13);
		rreg(REG_SYS_IO_CFG, d);
		chk("cfg rw", 8'h13, d);
		foreach (rows[i]) begin
			wreg(REG_SYS_IO_CFG, rows[i].cfg);
			host(rows[i]);
		end
		mux(8'h00, 0);
		chk("pp oe", 8'hFF, pd_oe_n);
		chk("pp ctl oe", 8'h1F, {3'h0, ctl_oe_n});
		chk("pp status", {3'h0, ctl_drv}, {3'h0, pp_status});
		@(posedge clock);
		pp_data_drive <= 1;
		mux(8'h01, 1);
		chk("pp data", pp_data_out, pd_out);
		chk("pp oe drv", 8'h00, pd_oe_n);
		chk("pp ctl", {4'h0, pp_ctl_out}, {4'h0, out_pins});
		mux(8'h01, 0);
		chk("fd oe", PD_FLOPPY_OE_N, pd_oe_n);
		chk("fd ctl oe", 8'h00, {3'h0, ctl_oe_n});
		chk("fd in", {pd_drv[7], 1'b0, pd_drv[5:0]}, fdc_in);
		chk("fd dens1", {7'h0, fdc_out[FO_DENS1]}, {7'h0, pd_out[PD_DENS1]});
		chk("fd ctl", {3'h0, fdc_out[5:1]}, {3'h0, ctl_out});
		chk("fd out", {5'h0, fdc_out[8:6]}, {5'h0, out_pins[3:1]});
		chk("fd pp in", 8'h00, pp_data_in);
		mux(8'h05, 1);
		chk("ecp", {5'h0, ecp_out}, {5'h0, out_pins[3], out_pins[1:0]});
		chk("ecp wait", {7'h0, ctl_drv[CTL_BUSY]}, {7'h0, pp_status[CTL_BUSY]});
		@(posedge clock);
		hc_port_power <= 2'h3;
		wreg(REG_USB_CTL, 8'h01);
		repeat (3) @(negedge clock);
		chk("power", 8'h02, {6'h0, port_power_ctl_n});
		@(posedge clock);
		oc_req <= 2'h2;
		hc_activity <= 1;
		repeat (8) @(negedge clock);
		chk("oc", 8'h02, {6'h0, hc_oc});
		chk("activity", 8'h01, {7'h0, usb_activity});
		irq_req <= 1;
		repeat (8) @(negedge clock);
		rreg(REG_IRQ_STAT, d);
		chk("status", 8'h0D, d);
		chk("masked", 8'h00, {7'h0, irq});
		wreg(REG_IRQ_MASK, 8'h01);
		repeat (3) @(negedge clock);
		chk("irq", 8'h01, {7'h0, irq});
		irq_req <= 0;
		wreg(REG_IRQ_STAT, 8'h0D);
		repeat (3) @(negedge clock);
		chk("irq clr", 8'h00, {7'h0, irq});
		rreg(REG_IRQ_STAT, d);
		chk("status clr", 8'h00, d);
		stop_test;
	end
endmodule // lspfm_top_tb_top
